// [design/bcr_mode_if.sv]
`default_nettype none
interface bcr_mode_if;
    logic enable;
    logic force_pwm;
    logic standby_on;
    logic burst_active;
    logic vout_low;
    logic light_load;
    logic pfm_mode;
    modport ctl (
        input enable, force_pwm, standby_on, burst_active, vout_low,
        input light_load,
        output pfm_mode
    );
    modport bank (
        output enable, force_pwm, standby_on, burst_active, vout_low,
        output light_load,
        input pfm_mode
    );
endinterface
`default_nettype wire

// [design/bcr_pfm_ctl.sv]
`default_nettype none
module bcr_pfm_ctl (
    input wire logic clock,
    input wire logic arst_n,
    bcr_mode_if.ctl port
);
    import bcr_pkg::*;

    logic pfm_q;
    logic [BURST_CNT_W-1:0] cnt_q;
    localparam logic [BURST_CNT_W-1:0] LIMIT = BURST_CNT_W'(BURST_LIMIT_CYC);

    assign port.pfm_mode = pfm_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pfm_q <= 1'b0;
            cnt_q <= '0;
        end else if (!port.enable) begin
            pfm_q <= 1'b0;
            cnt_q <= '0;
        end else if (port.standby_on) begin
            pfm_q <= 1'b1;
            cnt_q <= '0;
        end else if (port.force_pwm) begin
            pfm_q <= 1'b0;
            cnt_q <= '0;
        end else if (pfm_q) begin
            if (port.vout_low) begin
                pfm_q <= 1'b0;
            end else if (cnt_q > LIMIT) begin
                pfm_q <= 1'b0;
            end
            if (port.burst_active && cnt_q <= LIMIT) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end else if (port.light_load && !port.vout_low) begin
            // no re-entry while the output is still low
            pfm_q <= 1'b1;
            cnt_q <= '0;
        end
    end
endmodule
`default_nettype wire

// [design/bcr_pkg.sv]
`default_nettype none
package bcr_pkg;
    // register map
    localparam logic [7:0] REG_BUCK1_MAIN = 8'h10;
    localparam logic [7:0] REG_BUCK1_AUX = 8'h11;
    localparam logic [7:0] REG_BUCK1_STBY = 8'h12;
    localparam logic [7:0] REG_BUCK2_MAIN = 8'h13;
    localparam logic [5:0] REG_BLOCK = 6'h04;
    localparam int NUM_REGS = 4;
    localparam logic [1:0] IDX_B1_MAIN = 2'h0;
    localparam logic [1:0] IDX_B1_AUX = 2'h1;
    localparam logic [1:0] IDX_B1_STBY = 2'h2;
    localparam logic [1:0] IDX_B2_MAIN = 2'h3;
    // field positions
    localparam int MAIN_EN_BIT = 7;
    localparam int MAIN_RIPPLE_BIT = 6;
    localparam int MAIN_FPWM_BIT = 5;
    localparam int VCODE_W = 5;
    localparam int AUX_STBY_BIT = 6;
    localparam int AUX_DISCH_BIT = 5;
    localparam int AUX_PHASE_LSB = 3;
    localparam int AUX_SLEW_LSB = 0;
    localparam int STBY_PIN_LSB = 5;
    // reset values and writable bits, entry 0 in the low byte
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET =
        {8'h1d, 8'h10, 8'h16, 8'h10};
    localparam logic [NUM_REGS-1:0][7:0] REG_WMASK =
        {8'hff, 8'h1f, 8'h7f, 8'hff};
    // phase and slew codes
    localparam logic [1:0] PHASE_0 = 2'h0;
    localparam logic [1:0] PHASE_90 = 2'h1;
    localparam logic [1:0] PHASE_180 = 2'h2;
    localparam logic [1:0] PHASE_270 = 2'h3;
    localparam logic [2:0] SLEW_0P48 = 3'h1;
    localparam logic [2:0] SLEW_1P92 = 3'h3;
    localparam logic [2:0] SLEW_7P68 = 3'h5;
    localparam logic [2:0] SLEW_15P36 = 3'h6;
    localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
    // first converter voltage scale
    localparam logic [11:0] BUCK1_BASE_MV = 12'h258;
    localparam logic [11:0] BUCK1_STEP_MV = 12'h028;
    localparam logic [4:0] VCODE_1V24 = 5'h10;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BURST_LIMIT_NS = 10000;
    localparam int BURST_LIMIT_CYC = BURST_LIMIT_NS / CLK_PERIOD_NS;
    localparam int BURST_CNT_W = 11;
    // serial bus
    localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary value
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
    } bcr_state_type;
endpackage
`default_nettype wire

// [design/bcr_top.sv]
// Function
// - in pfm, except converter one in standby, fall back to pwm once accumulated burst time exceeds 10 us
// - in pfm, except converter one in standby, fall back to pwm when output drops 2% below target
// - force-pwm bit written by host keeps the converter in pwm, except converter one in standby, which stays in pfm
// - registers sit at hex 10, 11, 12 and 13
// - two-bit phase delays second clock 0/90/180/270 deg, default 180
// - three-bit slew code picks transition rate, default 15.36 mV/us
// - standby register bits 7..5 read pin 3..1 levels, bits 4..0 writable
// - normal and standby voltage codes of converter one reset to 1.24 V
// - voltage code is linear, 0.6 V plus 0.04 V per step for one
// - standby selects pfm and regulates to the standby voltage code
`default_nettype none
module bcr_top (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] pin_level,
    input wire logic [1:0] burst_active,
    input wire logic [1:0] vout_low,
    input wire logic [1:0] light_load,
    output logic buck1_on,
    output logic buck1_ripple_select,
    output logic buck1_force_pwm,
    output logic [bcr_pkg::VCODE_W-1:0] buck1_vcode,
    output logic [11:0] buck1_target_mv,
    output logic buck1_standby_on,
    output logic buck1_discharge_on,
    output logic [1:0] clock_phase,
    output logic [2:0] buck1_slew,
    output logic buck2_on,
    output logic buck2_ripple_select,
    output logic buck2_force_pwm,
    output logic [bcr_pkg::VCODE_W-1:0] buck2_vcode,
    output logic [1:0] pfm_mode
);
    import bcr_pkg::*;

    // two-flop synchronisers for every pin and analog status input
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic [2:0] pins_s;
    logic [1:0] burst_s, low_s, light_s;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= {2'h3, 9'h000};
            sync2_q <= {2'h3, 9'h000};
        end else begin
            sync1_q <= {scl_in, sda_in, pin_level, burst_active, vout_low,
                        light_load};
            sync2_q <= sync1_q;
        end
    end

    assign scl_s = sync2_q[10];
    assign sda_s = sync2_q[9];
    assign pins_s = sync2_q[8:6];
    assign burst_s = sync2_q[5:4];
    assign low_s = sync2_q[3:2];
    assign light_s = sync2_q[1:0];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    logic start_c, stop_c, scl_rise, scl_fall;
    assign start_c = scl_s && sda_p_q && !sda_s;
    assign stop_c = scl_s && !sda_p_q && sda_s;
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;

    // register storage
    logic [7:0] regs_q [NUM_REGS];
    logic wr_q;
    logic [7:0] wr_addr_q, wr_data_q, ptr_q, rd_data;

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    regs_q[i] <= REG_RESET[i];
                end else if (wr_q && wr_addr_q[7:2] == REG_BLOCK &&
                             wr_addr_q[1:0] == 2'(i)) begin
                    regs_q[i] <= wr_data_q & REG_WMASK[i];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data = 8'h00;
        if (ptr_q[7:2] == REG_BLOCK) begin
            rd_data = regs_q[ptr_q[1:0]];
            if (ptr_q[1:0] == IDX_B1_STBY) begin
                rd_data[7:STBY_PIN_LSB] = pins_s;
            end
        end
    end

    // serial bus slave
    bcr_state_type state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q;
    logic rw_q, have_ptr_q, nack_q, oe_q, sda_out_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            have_ptr_q <= 1'b0;
            nack_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            if (start_c) begin
                state_q <= ST_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_c) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else begin
                if (scl_rise) begin
                    if (state_q == ST_ADDR || state_q == ST_RX) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (state_q == ST_TX) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (state_q == ST_TX_ACK) begin
                        nack_q <= sda_s;
                    end
                end
                if (scl_fall) begin
                    unique case (state_q)
                        ST_IDLE: begin
                        end
                        ST_ADDR: if (cnt_q == BYTE_BITS) begin
                            if (sh_q[7:1] == DEV_ADDR) begin
                                state_q <= ST_ADDR_ACK;
                                oe_q <= 1'b1;
                                rw_q <= sh_q[0];
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_ADDR_ACK: begin
                            cnt_q <= 4'h0;
                            if (rw_q) begin
                                state_q <= ST_TX;
                                tx_q <= rd_data;
                                oe_q <= ~rd_data[7];
                            end else begin
                                state_q <= ST_RX;
                                oe_q <= 1'b0;
                                have_ptr_q <= 1'b0;
                            end
                        end
                        ST_RX: if (cnt_q == BYTE_BITS) begin
                            state_q <= ST_RX_ACK;
                            oe_q <= 1'b1;
                            if (have_ptr_q) begin
                                wr_q <= 1'b1;
                                wr_addr_q <= ptr_q;
                                wr_data_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                ptr_q <= sh_q;
                                have_ptr_q <= 1'b1;
                            end
                        end
                        ST_RX_ACK: begin
                            state_q <= ST_RX;
                            oe_q <= 1'b0;
                            cnt_q <= 4'h0;
                        end
                        ST_TX: if (cnt_q == BYTE_BITS) begin
                            state_q <= ST_TX_ACK;
                            oe_q <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                        end
                        ST_TX_ACK: if (nack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_TX;
                            cnt_q <= 4'h0;
                            tx_q <= rd_data;
                            oe_q <= ~rd_data[7];
                        end
                    endcase
                end
            end
        end
    end

    // open-drain data line only ever pulls low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe = oe_q;

    // target voltage selection
    logic [VCODE_W-1:0] vcode_q;
    logic [11:0] mv_q;
    logic [VCODE_W-1:0] vsel;
    assign vsel = regs_q[IDX_B1_AUX][AUX_STBY_BIT] ?
        regs_q[IDX_B1_STBY][VCODE_W-1:0] :
        regs_q[IDX_B1_MAIN][VCODE_W-1:0];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            vcode_q <= VCODE_1V24;
            mv_q <= 12'(BUCK1_BASE_MV + 12'(VCODE_1V24) * BUCK1_STEP_MV);
        end else begin
            vcode_q <= vsel;
            mv_q <= 12'(BUCK1_BASE_MV + 12'(vsel) * BUCK1_STEP_MV);
        end
    end

    // control fields straight from register flops, converter one voltage code and target through vcode_q and mv_q
    assign buck1_on = regs_q[IDX_B1_MAIN][MAIN_EN_BIT];
    assign buck1_ripple_select = regs_q[IDX_B1_MAIN][MAIN_RIPPLE_BIT];
    assign buck1_force_pwm = regs_q[IDX_B1_MAIN][MAIN_FPWM_BIT];
    assign buck1_vcode = vcode_q;
    assign buck1_target_mv = mv_q;
    assign buck1_standby_on = regs_q[IDX_B1_AUX][AUX_STBY_BIT];
    assign buck1_discharge_on = regs_q[IDX_B1_AUX][AUX_DISCH_BIT];
    assign clock_phase = regs_q[IDX_B1_AUX][AUX_PHASE_LSB+:2];
    assign buck1_slew = regs_q[IDX_B1_AUX][AUX_SLEW_LSB+:3];
    assign buck2_on = regs_q[IDX_B2_MAIN][MAIN_EN_BIT];
    assign buck2_ripple_select = regs_q[IDX_B2_MAIN][MAIN_RIPPLE_BIT];
    assign buck2_force_pwm = regs_q[IDX_B2_MAIN][MAIN_FPWM_BIT];
    assign buck2_vcode = regs_q[IDX_B2_MAIN][VCODE_W-1:0];

    // per-converter pfm/pwm mode control
    generate
        for (genvar c = 0; c < 2; c++) begin : g_mode
            localparam logic [1:0] MI = (c == 0) ? IDX_B1_MAIN : IDX_B2_MAIN;
            bcr_mode_if mif ();
            assign mif.enable = regs_q[MI][MAIN_EN_BIT];
            assign mif.force_pwm = regs_q[MI][MAIN_FPWM_BIT];
            assign mif.standby_on = (c == 0) ?
                regs_q[IDX_B1_AUX][AUX_STBY_BIT] : 1'b0;
            assign mif.burst_active = burst_s[c];
            assign mif.vout_low = low_s[c];
            assign mif.light_load = light_s[c];
            assign pfm_mode[c] = mif.pfm_mode;
            bcr_pfm_ctl u_ctl (
                .clock(clock),
                .arst_n(arst_n),
                .port(mif.ctl)
            );
        end
    endgenerate
endmodule
`default_nettype wire

// [test/bcr_top_monitor.sv]
`default_nettype none
module bcr_top_monitor
    import bcr_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] burst_active,
    input wire logic [1:0] vout_low,
    input wire logic buck1_on,
    input wire logic buck1_force_pwm,
    input wire logic [bcr_pkg::VCODE_W-1:0] buck1_vcode,
    input wire logic [11:0] buck1_target_mv,
    input wire logic buck1_standby_on,
    input wire logic buck2_on,
    input wire logic buck2_force_pwm,
    input wire logic [1:0] pfm_mode
);
    logic [10:0] burst_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            burst_q <= 11'h000;
        end else if (pfm_mode[0] && burst_active[0]) begin
            burst_q <= burst_q + 11'h001;
        end else begin
            burst_q <= 11'h000;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_TARGET_MV: assert property (
        buck1_target_mv == BUCK1_BASE_MV + BUCK1_STEP_MV * 12'(buck1_vcode))
        else $error("target voltage does not follow code");
    AST_OFF_ONE: assert property (
        !buck1_on [*2] |-> !pfm_mode[0])
        else $error("converter one off but in pfm");
    AST_OFF_TWO: assert property (
        !buck2_on [*2] |-> !pfm_mode[1])
        else $error("converter two off but in pfm");
    AST_FORCE_ONE: assert property (
        (buck1_force_pwm && !buck1_standby_on) [*2] |-> !pfm_mode[0])
        else $error("converter one forced pwm but in pfm");
    AST_FORCE_TWO: assert property (
        buck2_force_pwm [*2] |-> !pfm_mode[1])
        else $error("converter two forced pwm but in pfm");
    AST_STANDBY_PFM: assert property (
        (buck1_on && buck1_standby_on) [*2] |-> pfm_mode[0])
        else $error("standby without pfm");
    AST_VOUT_LOW: assert property (
        (vout_low[0] && !buck1_standby_on) [*5] |-> !pfm_mode[0])
        else $error("low output did not leave pfm");
    AST_BURST_LIMIT: assert property (
        burst_q < 11'h3f0)
        else $error("pfm burst lasted too long");
endmodule
bind bcr_top bcr_top_monitor i_bcr_top_monitor (
    .clock(clock), .arst_n(arst_n), .burst_active(burst_active),
    .vout_low(vout_low), .buck1_on(buck1_on),
    .buck1_force_pwm(buck1_force_pwm), .buck1_vcode(buck1_vcode),
    .buck1_target_mv(buck1_target_mv), .buck1_standby_on(buck1_standby_on),
    .buck2_on(buck2_on), .buck2_force_pwm(buck2_force_pwm),
    .pfm_mode(pfm_mode)
);
`default_nettype wire

// [test/tb_bcr_top.sv]
`default_nettype none
module tb_bcr_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bcr_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic scl = 1'b1;
    logic m_sda = 1'b1;
    logic [2:0] pin_level = 3'h5;
    logic [1:0] burst_active = 2'h0;
    logic [1:0] vout_low = 2'h0;
    logic [1:0] light_load = 2'h0;
    logic sda_w, sda_o, sda_oe, buck1_on, buck1_ripple_select;
    logic buck1_force_pwm;
    logic buck1_standby_on, buck1_discharge_on, buck2_on;
    logic buck2_ripple_select, buck2_force_pwm;
    logic [VCODE_W-1:0] buck1_vcode, buck2_vcode;
    logic [11:0] buck1_target_mv;
    logic [1:0] clock_phase, pfm_mode;
    logic [2:0] buck1_slew;
    int n_fail = 0;
    int compares = 0;
    assign sda_w = m_sda & ~sda_oe;
    bcr_top i_bcr_top (
        .clock(clock), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe(sda_oe), .pin_level(pin_level),
        .burst_active(burst_active), .vout_low(vout_low),
        .light_load(light_load), .buck1_on(buck1_on),
        .buck1_ripple_select(buck1_ripple_select),
        .buck1_force_pwm(buck1_force_pwm), .buck1_vcode(buck1_vcode),
        .buck1_target_mv(buck1_target_mv),
        .buck1_standby_on(buck1_standby_on),
        .buck1_discharge_on(buck1_discharge_on), .clock_phase(clock_phase),
        .buck1_slew(buck1_slew), .buck2_on(buck2_on),
        .buck2_ripple_select(buck2_ripple_select),
        .buck2_force_pwm(buck2_force_pwm), .buck2_vcode(buck2_vcode),
        .pfm_mode(pfm_mode)
    );
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic sbit(input logic b, output logic r);
        m_sda = b;
        tick(6);
        scl = 1'b1;
        tick(12);
        r = sda_w;
        scl = 1'b0;
        tick(6);
    endtask
    task automatic sbyte(input logic [7:0] d, input logic last,
                         output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
        sbit(last, ack);
    endtask
    task automatic start();
        m_sda = 1'b1;
        tick(6);
        scl = 1'b1;
        tick(12);
        m_sda = 1'b0;
        tick(12);
        scl = 1'b0;
        tick(6);
    endtask
    task automatic stop();
        m_sda = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(12);
        m_sda = 1'b1;
        tick(12);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic k0, k1, k2;
        start();
        sbyte({DEV_ADDR, 1'b0}, 1'b1, q, k0);
        sbyte(a, 1'b1, q, k1);
        sbyte(d, 1'b1, q, k2);
        stop();
        chk({9'h0, k0, k1, k2}, 12'h000);
        chk({11'h0, sda_o}, 12'h000);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        start();
        sbyte({DEV_ADDR, 1'b0}, 1'b1, q, k);
        sbyte(a, 1'b1, q, k);
        start();
        sbyte({DEV_ADDR, 1'b1}, 1'b1, q, k);
        sbyte(8'hff, 1'b1, q, k);
        stop();
        chk({4'h0, q}, {4'h0, e});
    endtask
    task automatic pm(input logic [1:0] e);
        tick(8);
        chk({10'h0, pfm_mode}, {10'h0, e});
    endtask
    task automatic t_defaults();
        chk(buck1_target_mv, 12'h4d8);
        chk({7'h0, buck1_vcode}, 12'h010);
        chk({10'h0, clock_phase}, 12'h002);
        chk({9'h0, buck1_slew}, 12'h006);
        rchk(8'h10, 8'h10);
        rchk(8'h11, 8'h16);
        rchk(8'h12, 8'hb0);
        rchk(8'h13, 8'h1d);
    endtask
    task automatic t_fields();
        wr(8'h10, 8'he3);
        tick(4);
        chk({buck1_on, buck1_ripple_select, buck1_force_pwm, buck1_vcode},
            12'h0e3);
        chk(buck1_target_mv, 12'h2d0);
        for (int p = 0; p < 4; p++) begin
            wr(8'h11, {3'h5, p[1:0], 3'h7});
            tick(4);
            chk({10'h0, clock_phase}, {10'h0, p[1:0]});
            rchk(8'h11, {3'h1, p[1:0], 3'h7});
        end
        chk({9'h0, buck1_slew}, 12'h007);
        chk({11'h0, buck1_discharge_on}, 12'h001);
        pin_level = 3'h2;
        wr(8'h12, 8'hff);
        rchk(8'h12, 8'h5f);
        wr(8'h20, 8'h55);
        rchk(8'h20, 8'h00);
    endtask
    task automatic t_pfm();
        int n;
        wr(8'h10, 8'h90);
        wr(8'h12, 8'h05);
        light_load = 2'h3;
        pm(2'h1);
        burst_active = 2'h1;
        n = 0;
        while (pfm_mode[0] === 1'b1 && n < 1100) begin
            tick(1);
            n++;
        end
        chk(12'(n > 1002 && n < 1008), 12'h001);
        burst_active = 2'h0;
        pm(2'h1);
        vout_low = 2'h1;
        pm(2'h0);
        vout_low = 2'h0;
        pm(2'h1);
        wr(8'h10, 8'hb0);
        pm(2'h0);
        wr(8'h13, 8'h9d);
        pm(2'h2);
        chk({buck2_on, buck2_ripple_select, buck2_force_pwm, buck2_vcode},
            12'h09d);
        wr(8'h13, 8'hfd);
        pm(2'h0);
        chk({buck2_on, buck2_ripple_select, buck2_force_pwm, buck2_vcode},
            12'h0fd);
        wr(8'h11, 8'h46);
        pm(2'h1);
        chk({7'h0, buck1_vcode}, 12'h005);
        chk(buck1_target_mv, 12'h320);
        light_load = 2'h0;
    endtask
    task automatic t_reset();
        wr(8'h13, 8'h80);
        arst_n = 1'b0;
        tick(2);
        chk({10'h0, pfm_mode}, 12'h000);
        chk({7'h0, buck2_vcode}, 12'h01d);
        chk({11'h0, buck1_standby_on}, 12'h000);
        chk(buck1_target_mv, 12'h4d8);
        arst_n = 1'b1;
        tick(3);
        rchk(8'h11, 8'h16);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        finish_test();
    end
    initial begin
        tick(6);
        arst_n = 1'b1;
        tick(3);
        t_defaults();
        t_fields();
        t_pfm();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
